// ---- src/ddp_data_path.sv ----
`timescale 1ns/1ps
module ddp_data_path #(
	parameter logic [7:0] SYNC_CHAR = 8'h01
) (
	input wire logic mclk_in, // Core clock, 125 MHz.
	input wire logic rst_in, // Asynchronous reset, active high.
	input wire logic srl_clk_in, // Drive shift clock, link domain.
	input wire logic [2:0] reg_sel_in, // Register index.
	input wire logic reg_wr_in, // Register write strobe.
	input wire logic [15:0] reg_wdata_in, // Register write data.
	output logic [15:0] reg_rdata_out, // Registered read data.
	input wire ddp_pkg::ddp_port_t bus_a_in, // Controller A port pins.
	input wire ddp_pkg::ddp_port_t bus_b_in, // Controller B port pins.
	input wire logic second_port_owns_drive_in, // High gives the drive to port B.
	input wire logic write_clk_echo_in, // Echoed write clock pin.
	output logic bus_sync_clk_out, // Buffer ready, asks for a word.
	output logic parity_error_out, // Parity fault on the last loaded word.
	output logic run_out, // Selected port run level.
	input wire logic read_path_select_in, // High during reads.
	input wire logic [17:0] rd_word_in, // Assembled word from read side.
	input wire logic rd_strobe_in, // Read word ready pulse.
	output logic [17:0] bus_data_out, // Data buffer contents.
	output logic buffer_load_strobe_out, // Buffer capture pulse.
	input wire logic sync_char_insert_in, // Put sync char in next word.
	input wire logic write_gate_in, // Write gating enable.
	input wire logic [4:0] sector_count_in, // Running sector count.
	input wire logic [4:0] desired_sector_in, // Desired sector address.
	input wire logic header_match_in, // Header compare hit.
	input wire logic crc_ok_in, // Header CRC good.
	output logic sector_found_out, // Target sector identified.
	input wire logic read_error_in, // Error seen at end of read transfer.
	input wire logic corr_done_in, // Correction result ready.
	input wire logic corr_hard_in, // Result is uncorrectable.
	input wire logic [15:0] corr_position_in, // Burst position result.
	input wire logic [10:0] corr_pattern_in, // Burst pattern result.
	output logic corr_start_out, // Start correction pulse.
	output logic data_check_error_out, // Data check flag.
	output logic uncorrectable_error_flag_out, // Uncorrectable flag.
	input wire logic [9:0] actual_cyl_in, // Head cylinder from drive pins.
	input wire logic [15:0] drv_err_two_in, // Drive error lines, group two.
	input wire logic [15:0] drv_err_three_in, // Drive error lines, group three.
	output logic offset_direction_bit_out, // Offset sign, high is negative.
	output logic [10:0] offset_magnitude_out, // Offset in microinches.
	output logic sixteen_bit_format_select_out, // Sixteen bit word mode.
	output logic shift_register_load_out, // Shift register load, link domain.
	output logic drive_data_level_out // Phase setup flip-flop, link domain.
);
	localparam int PW = $bits(ddp_pkg::ddp_port_t);

	// Software registers and status.
	logic [15:0] head_offset_control;
	logic [15:0] target_cylinder;
	logic [9:0] present_cylinder;
	logic [15:0] drive_error_two;
	logic [15:0] drive_error_three;
	logic [15:0] correction_position;
	logic [10:0] correction_pattern;
	logic data_check_error;
	logic uncorrectable_error_flag;

	// Pin synchronisers in the core domain.
	logic [PW-1:0] bus_a_s1, bus_a_s2, bus_b_s1, bus_b_s2;
	logic own_s1, own_s2, echo_s1, echo_s2, echo_s3;
	logic [9:0] cyl_s1, cyl_s2;
	logic [15:0] e2_s1, e2_s2, e3_s1, e3_s2;
	logic ack_s1, ack_s2;

	// Buffer and handshake toward the shift domain.
	logic [17:0] data_buffer;
	logic buf_full, buf_sync, xfer_req;
	ddp_pkg::ddp_xfer_t xfer_hold;

	// Link domain state.
	logic fmt_s1, fmt_s2, wen_s1, wen_s2, req_s1, req_s2, xfer_ack;
	logic [17:0] shreg;
	logic [4:0] bit_cnt;

	// Decode of the register port.
	wire wr_offset = reg_wr_in && (reg_sel_in == ddp_pkg::IDX_OFFSET);
	wire wr_target = reg_wr_in && (reg_sel_in == ddp_pkg::IDX_TARGET_CYL);
	wire wr_err_one = reg_wr_in && (reg_sel_in == ddp_pkg::IDX_ERROR_ONE);
	wire header_compare_inhibit = head_offset_control[ddp_pkg::HDR_INHIBIT_BIT];
	wire correction_inhibit = target_cylinder[ddp_pkg::CORR_INHIBIT_BIT];
	wire fmt16 = head_offset_control[ddp_pkg::FMT16_BIT];
	wire [15:0] err_one_val = {data_check_error, 8'h00, uncorrectable_error_flag, 6'h00};
	logic [15:0] next_rdata;
	always_comb begin
		unique case (reg_sel_in)
			ddp_pkg::IDX_OFFSET: next_rdata = head_offset_control;
			ddp_pkg::IDX_TARGET_CYL: next_rdata = target_cylinder;
			ddp_pkg::IDX_PRESENT_CYL: next_rdata = {6'h00, present_cylinder};
			ddp_pkg::IDX_ERROR_ONE: next_rdata = err_one_val;
			ddp_pkg::IDX_ERROR_TWO: next_rdata = drive_error_two;
			ddp_pkg::IDX_ERROR_THREE: next_rdata = drive_error_three;
			ddp_pkg::IDX_CORR_POS: next_rdata = correction_position;
			ddp_pkg::IDX_CORR_PAT: next_rdata = {5'h00, correction_pattern};
		endcase
	end

	// Head offset decode: sign bit and two magnitude bits.
	wire [1:0] mag_code = head_offset_control[ddp_pkg::OFS_MAG_HI:ddp_pkg::OFS_MAG_LO];
	wire on_center = (head_offset_control[ddp_pkg::OFS_CODE_HI:0] == 8'h00);
	wire [10:0] next_mag = on_center ? ddp_pkg::MAG_NONE :
		(mag_code == 2'h1) ? ddp_pkg::MAG_400 :
		(mag_code == 2'h2) ? ddp_pkg::MAG_800 :
		(mag_code == 2'h3) ? ddp_pkg::MAG_1200 : ddp_pkg::MAG_NONE;
	// A zero magnitude leaves the heads on centerline, so no direction is shown.
	wire next_dir = !on_center && (mag_code != 2'h0) &&
		head_offset_control[ddp_pkg::OFS_DIR_BIT];

	// Sector identification, with or without header compare.
	wire next_found = header_compare_inhibit ? (sector_count_in == desired_sector_in) :
		(header_match_in && crc_ok_in);

	// Error flags; a new event wins over a software clear.
	wire check_set = read_error_in;
	wire hard_set = corr_done_in && corr_hard_in;
	wire next_check = check_set || (data_check_error &&
		!(wr_err_one && reg_wdata_in[ddp_pkg::ERR1_CHECK_BIT]));
	wire next_hard = hard_set || (uncorrectable_error_flag &&
		!(wr_err_one && reg_wdata_in[ddp_pkg::ERR1_HARD_BIT]));
	wire next_start = read_error_in && !correction_inhibit;

	// Input multiplexer and buffer load strobe.
	ddp_pkg::ddp_port_t sel_port;
	assign sel_port = own_s2 ? ddp_pkg::ddp_port_t'(bus_b_s2) :
		ddp_pkg::ddp_port_t'(bus_a_s2);
	wire echo_rise = echo_s2 && !echo_s3;
	wire load_strobe = read_path_select_in ? rd_strobe_in : echo_rise;
	wire [17:0] buf_src = read_path_select_in ? rd_word_in : sel_port.data;
	wire next_par_err = !read_path_select_in && !(^{sel_port.data, sel_port.parity});
	wire launch = buf_full && (xfer_req == ack_s2) && !read_path_select_in;
	wire next_ready = !buf_full && !read_path_select_in;

	// Synchronisers for pins and the returning acknowledge.
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			{bus_a_s1, bus_a_s2, bus_b_s1, bus_b_s2} <= '0;
			{own_s1, own_s2, echo_s1, echo_s2, echo_s3} <= 5'h00;
			{cyl_s1, cyl_s2} <= 20'h00000;
			{e2_s1, e2_s2, e3_s1, e3_s2} <= 64'h0000000000000000;
			{ack_s1, ack_s2} <= 2'h0;
		end else begin
			bus_a_s1 <= bus_a_in;
			bus_a_s2 <= bus_a_s1;
			bus_b_s1 <= bus_b_in;
			bus_b_s2 <= bus_b_s1;
			{own_s1, own_s2} <= {second_port_owns_drive_in, own_s1};
			{echo_s1, echo_s2, echo_s3} <= {write_clk_echo_in, echo_s1, echo_s2};
			{cyl_s1, cyl_s2} <= {actual_cyl_in, cyl_s1};
			{e2_s1, e2_s2} <= {drv_err_two_in, e2_s1};
			{e3_s1, e3_s2} <= {drv_err_three_in, e3_s1};
			{ack_s1, ack_s2} <= {xfer_ack, ack_s1};
		end
	end

	// Software written registers.
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			head_offset_control <= ddp_pkg::OFFSET_RST;
			target_cylinder <= ddp_pkg::TARGET_RST;
		end else begin
			if (wr_offset)
				head_offset_control <= reg_wdata_in;
			if (wr_target)
				target_cylinder <= {reg_wdata_in[15:ddp_pkg::CYL_W], reg_wdata_in[9:0]};
		end
	end

	// Drive status and correction result registers.
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			present_cylinder <= 10'h000;
			drive_error_two <= 16'h0000;
			drive_error_three <= 16'h0000;
			correction_position <= 16'h0000;
			correction_pattern <= 11'h000;
			data_check_error <= 1'b0;
			uncorrectable_error_flag <= 1'b0;
		end else begin
			present_cylinder <= cyl_s2;
			drive_error_two <= e2_s2;
			drive_error_three <= e3_s2;
			if (corr_done_in) begin
				correction_position <= corr_position_in;
				correction_pattern <= corr_pattern_in;
			end
			data_check_error <= next_check;
			uncorrectable_error_flag <= next_hard;
		end
	end

	// Data buffer and toggle handshake toward the shift register.
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			data_buffer <= 18'h00000;
			buf_full <= 1'b0;
			buf_sync <= 1'b0;
			xfer_req <= 1'b0;
			xfer_hold <= '0;
		end else begin
			if (load_strobe) begin
				data_buffer <= buf_src;
				buf_sync <= sync_char_insert_in;
			end
			if (launch) begin
				xfer_hold <= '{word: data_buffer, sync: buf_sync};
				xfer_req <= !xfer_req;
			end
			if (load_strobe && !read_path_select_in)
				buf_full <= 1'b1;
			else if (launch)
				buf_full <= 1'b0;
		end
	end

	// Registered outputs of the core domain.
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			reg_rdata_out <= 16'h0000;
			bus_sync_clk_out <= 1'b0;
			parity_error_out <= 1'b0;
			run_out <= 1'b0;
			bus_data_out <= 18'h00000;
			buffer_load_strobe_out <= 1'b0;
			sector_found_out <= 1'b0;
			corr_start_out <= 1'b0;
			data_check_error_out <= 1'b0;
			uncorrectable_error_flag_out <= 1'b0;
			offset_direction_bit_out <= 1'b0;
			offset_magnitude_out <= 11'h000;
			sixteen_bit_format_select_out <= 1'b0;
		end else begin
			reg_rdata_out <= next_rdata;
			bus_sync_clk_out <= next_ready;
			if (load_strobe)
				parity_error_out <= next_par_err;
			run_out <= sel_port.run;
			bus_data_out <= data_buffer;
			buffer_load_strobe_out <= load_strobe;
			sector_found_out <= next_found;
			corr_start_out <= next_start;
			data_check_error_out <= next_check;
			uncorrectable_error_flag_out <= next_hard;
			offset_direction_bit_out <= next_dir;
			offset_magnitude_out <= next_mag;
			sixteen_bit_format_select_out <= fmt16;
		end
	end

	// Link domain: word length, reload point and sync insertion.
	wire [4:0] word_len = fmt_s2 ? ddp_pkg::LEN16 : ddp_pkg::LEN18;
	wire reload = (bit_cnt == 5'h00);
	wire have_word = (req_s2 != xfer_ack);
	wire [17:0] hold_word = fmt_s2 ? {2'h0, xfer_hold.word[15:0]} : xfer_hold.word;
	wire [17:0] load_word = !have_word ? 18'h00000 :
		xfer_hold.sync ? {hold_word[17:ddp_pkg::SYNC_W], SYNC_CHAR} : hold_word;
	wire [4:0] next_cnt = reload ? 5'(word_len - 5'h01) : 5'(bit_cnt - 5'h01);

	// Shift register, write gating and phase setup flip-flop.
	always_ff @(posedge srl_clk_in or posedge rst_in) begin
		if (rst_in) begin
			{fmt_s1, fmt_s2, wen_s1, wen_s2, req_s1, req_s2} <= 6'h00;
			xfer_ack <= 1'b0;
			shreg <= 18'h00000;
			bit_cnt <= 5'h00;
			shift_register_load_out <= 1'b0;
			drive_data_level_out <= 1'b0;
		end else begin
			{fmt_s1, fmt_s2} <= {fmt16, fmt_s1};
			{wen_s1, wen_s2} <= {write_gate_in, wen_s1};
			{req_s1, req_s2} <= {xfer_req, req_s1};
			bit_cnt <= next_cnt;
			shift_register_load_out <= reload;
			if (reload) begin
				shreg <= load_word;
				if (have_word)
					xfer_ack <= req_s2;
			end else begin
				shreg <= {1'b0, shreg[17:1]};
			end
			drive_data_level_out <= wen_s2 && shreg[0];
		end
	end
endmodule

// ---- src/ddp_pkg.sv ----
// Summary of operation
// - Offset top bit sign, bits 5:4 magnitude.
// - Header inhibit matches sector count only.
// - Read error starts correction, sets data check.
// - Uncorrectable result also sets uncorrectable flag.
// - Correction inhibit skips correction, keeps data check.
// - Target cylinder holds ten address bits.
// - Present cylinder follows actual head position.
// - Error registers two, three capture drive errors.
// - Correction done loads burst position register.
// - Pattern register holds eleven bit burst.
// - Port ownership selects bus B, else A.
// - Selected parity checked, run passed onward.
// - Writes load buffer from input multiplexer.
// - Buffer captures each word on load strobe.
// - Ready buffer sends bus sync clock.
// - Buffered word loads shift register in parallel.
// - Sync insert replaces low eight bits.
// - Serial bits pass gating and phase flip-flop.
// - Reload after 18 or 16 shifts, LSB first.
// - Offset bit 12 selects sixteen bit mode.
// - Offset bits 7:0 are the head offset code.
package ddp_pkg;
	localparam int WORD_W = 18;
	localparam int REG_W = 16;
	localparam int SEL_W = 3;
	// Register indices on the register select port.
	localparam logic [2:0] IDX_OFFSET = 3'h0;
	localparam logic [2:0] IDX_TARGET_CYL = 3'h1;
	localparam logic [2:0] IDX_PRESENT_CYL = 3'h2;
	localparam logic [2:0] IDX_ERROR_ONE = 3'h3;
	localparam logic [2:0] IDX_ERROR_TWO = 3'h4;
	localparam logic [2:0] IDX_ERROR_THREE = 3'h5;
	localparam logic [2:0] IDX_CORR_POS = 3'h6;
	localparam logic [2:0] IDX_CORR_PAT = 3'h7;
	// Field positions.
	localparam int OFS_DIR_BIT = 7;
	localparam int OFS_MAG_HI = 5;
	localparam int OFS_MAG_LO = 4;
	localparam int OFS_CODE_HI = 7;
	localparam int HDR_INHIBIT_BIT = 11;
	localparam int CORR_INHIBIT_BIT = 11;
	localparam int FMT16_BIT = 12;
	localparam int CYL_W = 10;
	localparam int PAT_W = 11;
	localparam int ERR1_CHECK_BIT = 15;
	localparam int ERR1_HARD_BIT = 6;
	localparam int SYNC_W = 8;
	// Reset values and word lengths.
	localparam logic [15:0] OFFSET_RST = 16'h0000;
	localparam logic [15:0] TARGET_RST = 16'h0000;
	localparam logic [4:0] LEN16 = 5'h10;
	localparam logic [4:0] LEN18 = 5'h12;
	// Offset magnitudes in microinches.
	localparam logic [10:0] MAG_NONE = 11'h000;
	localparam logic [10:0] MAG_400 = 11'h190;
	localparam logic [10:0] MAG_800 = 11'h320;
	localparam logic [10:0] MAG_1200 = 11'h4b0;
	// One controller port: data word, parity and run.
	typedef struct packed {
		logic [WORD_W-1:0] data;
		logic parity;
		logic run;
	} ddp_port_t;
	// Word handed from the buffer to the shift register domain.
	typedef struct packed {
		logic [WORD_W-1:0] word;
		logic sync;
	} ddp_xfer_t;
endpackage

// ---- bench/ddp_data_path_properties.sv ----
`timescale 1ns/1ps
// Watches the data path ports for the offset, error and load-handshake behaviour.
module ddp_data_path_properties (
	input wire logic mclk_in, // Core clock.
	input wire logic rst_in, // Reset.
	input wire logic srl_clk_in, // Link clock.
	input wire logic [2:0] reg_sel_in, // Index.
	input wire logic reg_wr_in, // Write.
	input wire logic [15:0] reg_wdata_in, // Data.
	input wire logic read_error_in, // Read error.
	input wire logic corr_done_in, // Result ready.
	input wire logic corr_hard_in, // Uncorrectable.
	input wire logic corr_start_out, // Start.
	input wire logic data_check_error_out, // Check flag.
	input wire logic uncorrectable_error_flag_out, // Hard flag.
	input wire logic offset_direction_bit_out, // Sign.
	input wire logic sixteen_bit_format_select_out, // Mode.
	input wire logic buffer_load_strobe_out, // Load pulse.
	input wire logic bus_sync_clk_out, // Ready.
	input wire logic write_clk_echo_in, // Echo.
	input wire logic read_path_select_in, // Reading.
	input wire logic shift_register_load_out // Link load.
);
	logic inhibit_shadow, seen;
	logic [4:0] cnt;
	wire logic wr_ofs = reg_wr_in && reg_sel_in == 3'h0;
	// Shadow of the correction inhibit bit, kept from register writes.
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in)
			inhibit_shadow <= 1'b0;
		else if (reg_wr_in && reg_sel_in == ddp_pkg::IDX_TARGET_CYL)
			inhibit_shadow <= reg_wdata_in[ddp_pkg::CORR_INHIBIT_BIT];
	end
	// Counts link edges between loads; the first load after reset has no predecessor.
	always_ff @(posedge srl_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt <= 5'h00;
			seen <= 1'b0;
		end else begin
			cnt <= shift_register_load_out ? 5'h00 : cnt + 5'h01;
			seen <= seen | shift_register_load_out;
		end
	end
	a_start_on_error: assert property (@(posedge mclk_in) disable iff (rst_in)
		read_error_in && !inhibit_shadow |=> corr_start_out && data_check_error_out)
		else $error("No start.");
	a_inhibit_holds_start: assert property (@(posedge mclk_in) disable iff (rst_in)
		read_error_in && inhibit_shadow |=> !corr_start_out && data_check_error_out)
		else $error("Bad inhibit.");
	a_hard_flag_set: assert property (@(posedge mclk_in) disable iff (rst_in)
		corr_done_in && corr_hard_in |=> uncorrectable_error_flag_out) else $error("No hard flag.");
	a_offset_sign_decode: assert property (@(posedge mclk_in) disable iff (rst_in)
		wr_ofs ##1 !wr_ofs |=> offset_direction_bit_out ==
		($past(reg_wdata_in[7], 2) && $past(reg_wdata_in[5:4], 2) != 2'h0)) else $error("Bad sign.");
	a_format_bit: assert property (@(posedge mclk_in) disable iff (rst_in)
		wr_ofs ##1 !wr_ofs |=> sixteen_bit_format_select_out == $past(reg_wdata_in[12], 2))
		else $error("Bad word mode.");
	a_strobe_one_pulse: assert property (@(posedge mclk_in) disable iff (rst_in)
		buffer_load_strobe_out |=> !bus_sync_clk_out && !buffer_load_strobe_out)
		else $error("Bad pulse.");
	a_echo_loads_buffer: assert property (@(posedge mclk_in) disable iff (rst_in)
		$rose(write_clk_echo_in) && bus_sync_clk_out && !read_path_select_in |-> ##[2:6]
		buffer_load_strobe_out) else $error("Echo not loaded.");
	a_load_spacing: assert property (@(posedge srl_clk_in) disable iff (rst_in)
		shift_register_load_out && seen |-> cnt == 5'h0f || cnt == 5'h11) else $error("Bad spacing.");
	// Main scenarios reached.
	cover property (@(posedge mclk_in) corr_start_out);
	cover property (@(posedge mclk_in) buffer_load_strobe_out && !read_path_select_in);
	cover property (@(posedge mclk_in) read_error_in && inhibit_shadow);
endmodule
bind ddp_data_path ddp_data_path_properties chk (.*);

// ---- bench/ddp_ctrl_model.sv ----
`timescale 1ns/1ps
// Controller model: answers each bus sync clock with a word and an echoed write clock.
module ddp_ctrl_model (
	input wire logic mclk_in, // Core clock.
	input wire logic sync_in, // Bus sync clock from the device.
	input wire logic owns_b_in, // High when port B owns the drive.
	input wire logic slow_in, // High makes the answer slow.
	input wire logic [17:0] word_in, // Base word; the send count is added.
	output ddp_pkg::ddp_port_t bus_a_out, // Port A pins.
	output ddp_pkg::ddp_port_t bus_b_out, // Port B pins.
	output logic echo_out, // Echoed write clock.
	output int sent_out // Echoes given so far.
);
	// Only the owning port carries the word; the other shows its inverse, never a copy.
	task automatic put();
		logic [17:0] d;
		d = word_in + 18'(sent_out);
		bus_a_out = '{data: owns_b_in ? ~d : d, parity: ~^d, run: !owns_b_in};
		bus_b_out = '{data: owns_b_in ? d : ~d, parity: ~^d, run: owns_b_in};
	endtask
	// One word per high period of the sync clock, held well around the echo.
	initial begin
		echo_out = 1'b0;
		sent_out = 0;
		put();
		forever begin
			@(posedge mclk_in);
			#2;
			if (sync_in) begin
				repeat (slow_in ? 8 : 1) @(posedge mclk_in);
				#2;
				put();
				repeat (3) @(posedge mclk_in);
				#2;
				echo_out = 1'b1;
				sent_out = sent_out + 1;
				repeat (4) @(posedge mclk_in);
				#2;
				echo_out = 1'b0;
			end
		end
	end
endmodule

// ---- bench/test_disk_data_path_ecc_control.sv ----
`timescale 1ns/1ps
// Offset codes from a table, then registers, errors, ports and the read path.
module test_disk_data_path_ecc_control;
	typedef struct packed {
		logic [15:0] w;
		logic d;
		logic [10:0] m;
		logic f;
	} ddp_row_t;
	logic mclk_in = 1'b0, srl_clk_in = 1'b0, rst_in = 1'b1, reg_wr_in = 1'b0, slow = 1'b0;
	logic [2:0] reg_sel_in = 3'h0;
	logic [15:0] reg_wdata_in = 16'h0, drv_err_two_in = 16'h0, drv_err_three_in = 16'h0;
	logic [15:0] corr_position_in = 16'h0, reg_rdata_out;
	logic [10:0] corr_pattern_in = 11'h0, offset_magnitude_out;
	logic [9:0] actual_cyl_in = 10'h0;
	logic [17:0] rd_word_in = 18'h0, bus_data_out, word = 18'h2a5c3;
	logic [4:0] sector_count_in = 5'h0b, desired_sector_in = 5'h0b;
	logic second_port_owns_drive_in = 1'b0, read_path_select_in = 1'b0, rd_strobe_in = 1'b0;
	logic sync_char_insert_in = 1'b0, write_gate_in = 1'b1, header_match_in = 1'b0;
	logic crc_ok_in = 1'b0, read_error_in = 1'b0, corr_done_in = 1'b0, corr_hard_in = 1'b1;
	ddp_pkg::ddp_port_t bus_a_in, bus_b_in;
	logic write_clk_echo_in, bus_sync_clk_out, parity_error_out, run_out, buffer_load_strobe_out;
	logic sector_found_out, corr_start_out, data_check_error_out, uncorrectable_error_flag_out;
	logic offset_direction_bit_out, sixteen_bit_format_select_out, shift_register_load_out;
	logic drive_data_level_out;
	int err_count = 0, compares = 0, sent, i;
	ddp_row_t rows[8] = '{'{16'h0010, 1'b0, 11'h190, 1'b0}, '{16'h0090, 1'b1, 11'h190, 1'b0},
		'{16'h0020, 1'b0, 11'h320, 1'b0}, '{16'h10a0, 1'b1, 11'h320, 1'b1},
		'{16'h0030, 1'b0, 11'h4b0, 1'b0}, '{16'h00b0, 1'b1, 11'h4b0, 1'b0},
		'{16'h1080, 1'b0, 11'h000, 1'b1}, '{16'h0000, 1'b0, 11'h000, 1'b0}};
	ddp_data_path DUT (.*);
	ddp_ctrl_model ctrl (.mclk_in(mclk_in), .sync_in(bus_sync_clk_out),
		.owns_b_in(second_port_owns_drive_in), .slow_in(slow), .word_in(word), .bus_a_out(bus_a_in),
		.bus_b_out(bus_b_in), .echo_out(write_clk_echo_in), .sent_out(sent));
	// Core clock at 8 ns and an unrelated link clock at 160 ns.
	initial begin
		forever #4 mclk_in = ~mclk_in;
	end
	initial begin
		#37;
		forever #80 srl_clk_in = ~srl_clk_in;
	end
	// Collects the serial stream, newest bit on top, and keeps the word ended by each load pulse.
	logic [17:0] ser = 18'h00000, last_ser = 18'h00000;
	always @(posedge srl_clk_in) begin
		ser = {drive_data_level_out, ser[17:1]};
		if (shift_register_load_out === 1'b1)
			last_ser = ser;
	end
	task automatic chk(input string n, input logic [17:0] e, input logic [17:0] g);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask
	task automatic wr(input logic [2:0] s, input logic [15:0] d);
		step(1);
		reg_sel_in = s;
		reg_wdata_in = d;
		reg_wr_in = 1'b1;
		step(1);
		reg_wr_in = 1'b0;
	endtask
	task automatic rchk(input string n, input logic [2:0] s, input logic [15:0] e);
		step(1);
		reg_sel_in = s;
		step(1);
		chk(n, {2'h0, e}, {2'h0, reg_rdata_out});
	endtask
	task automatic pulse(ref logic p);
		step(1);
		p = 1'b1;
		step(1);
		p = 1'b0;
	endtask
	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Waits a bounded time for the next buffer load pulse.
	task automatic wait_load();
		for (i = 0; i < 900 && buffer_load_strobe_out !== 1'b1; i++)
			step(1);
		if (i == 900) begin
			err_count++;
			end_sim();
		end
	endtask
	// Main sequence.
	initial begin
		repeat (2) @(posedge srl_clk_in);
		step(1);
		rst_in = 1'b0;
		step(3);
		rchk("offset reset", 3'h0, ddp_pkg::OFFSET_RST);
		rchk("target reset", 3'h1, ddp_pkg::TARGET_RST);
		foreach (rows[k]) begin
			wr(3'h0, rows[k].w);
			step(2);
			chk("sign", {17'h0, rows[k].d}, {17'h0, offset_direction_bit_out});
			chk("size", {7'h0, rows[k].m}, {7'h0, offset_magnitude_out});
			chk("mode", {17'h0, rows[k].f}, {17'h0, sixteen_bit_format_select_out});
			rchk("offset", 3'h0, rows[k].w);
		end
		actual_cyl_in = 10'h19a;
		drv_err_two_in = 16'ha5c3;
		drv_err_three_in = 16'h3c5a;
		wr(3'h2, 16'hffff);
		step(3);
		rchk("present cyl", 3'h2, 16'h019a);
		rchk("errors two", 3'h4, 16'ha5c3);
		rchk("errors three", 3'h5, 16'h3c5a);
		wr(3'h1, 16'h019a);
		rchk("target cyl", 3'h1, 16'h019a);
		wr(3'h0, 16'h0800);
		step(2);
		chk("count hit", 18'h1, {17'h0, sector_found_out});
		desired_sector_in = 5'h0c;
		header_match_in = 1'b1;
		crc_ok_in = 1'b1;
		step(2);
		chk("count miss", 18'h0, {17'h0, sector_found_out});
		wr(3'h0, 16'h0000);
		step(2);
		chk("header hit", 18'h1, {17'h0, sector_found_out});
		corr_position_in = 16'h0123;
		corr_pattern_in = 11'h5a5;
		pulse(read_error_in);
		chk("start", 18'h3, {16'h0, corr_start_out, data_check_error_out});
		pulse(corr_done_in);
		step(1);
		chk("hard", 18'h1, {17'h0, uncorrectable_error_flag_out});
		rchk("position", 3'h6, 16'h0123);
		rchk("pattern", 3'h7, 16'h05a5);
		wr(3'h3, 16'h8040);
		chk("cleared", 18'h0, {16'h0, data_check_error_out, uncorrectable_error_flag_out});
		wr(3'h1, 16'h0800);
		pulse(read_error_in);
		chk("inhibited", 18'h1, {16'h0, corr_start_out, data_check_error_out});
		for (int n = 0; n < 6; n++) begin
			wait_load();
			step(1);
			chk("word", word + 18'(sent - 1), bus_data_out);
			chk("parity run", 18'h1, {16'h0, parity_error_out, run_out});
			step(1);
			second_port_owns_drive_in = (n >= 2);
			slow = (n >= 2);
		end
		// Sixteen bit words with the sync character, checked as they leave the link.
		sync_char_insert_in = 1'b1;
		wr(3'h0, 16'h1000);
		step(2000);
		chk("serial word", 18'h0a501, {2'h0, last_ser[17:2]});
		write_gate_in = 1'b0;
		step(120);
		chk("gated", 18'h0, {17'h0, drive_data_level_out});
		wait_load();
		step(1);
		read_path_select_in = 1'b1;
		rd_word_in = 18'h1f00e;
		pulse(rd_strobe_in);
		step(2);
		chk("read word", 18'h1f00e, bus_data_out);
		end_sim();
	end
endmodule
